// ===== hw/rsrc_defines.vh
// Purpose: Constants for the reset and stop recovery controller.
// Assumes: 200 MHz system clock; register words on AHB-Lite.
// Notes:   Definitions only.
`ifndef RSRC_DEFINES_VH
`define RSRC_DEFINES_VH
// =============================================================
// Timing
// =============================================================
`define RSRC_HOLD_SHORT      13'h0042
`define RSRC_HOLD_LONG       13'h1388
`define RSRC_OSC_START_NS    4000
`define RSRC_CLK_PERIOD_NS   5
`define RSRC_OSC_START_CYC   13'h0320
`define RSRC_PIN_FILT_CYC    3'h4
// =============================================================
// Register map (byte addresses)
// =============================================================
`define RSRC_ADDR_CAUSE      12'h000
`define RSRC_ADDR_WDCTL      12'h004
`define RSRC_ADDR_CLKCTL     12'h008
`define RSRC_ADDR_DBGCTL     12'h00C
`define RSRC_ADDR_CFG        12'h010
`define RSRC_ADDR_STAT       12'h014
// =============================================================
// Fields and reset values
// =============================================================
`define RSRC_CAUSE_POR       7
`define RSRC_CAUSE_STOP      6
`define RSRC_CAUSE_WDOG      5
`define RSRC_CAUSE_PIN       4
`define RSRC_CLKCTL_RST      8'hA0
`define RSRC_WDCTL_RST       8'h00
`define RSRC_DEBUG_RST_BIT   0
`define RSRC_CFG_WDRES       0
`define RSRC_CFG_XTAL        1
`define RSRC_CFG_BOAO        2
`define RSRC_CFG_PINEN       3
`define RSRC_CFG_RST         8'h0D
`define RSRC_VEC_HI          16'h0002
`define RSRC_VEC_LO          16'h0003
`endif

// ===== hw/rsrc_pin_filter.v
// Purpose: Glitch filter for the active-low reset pin input.
// Assumes: Input already synchronous to clk_sys.
// Notes:   Asserted only after a run of low samples.
`timescale 1ns/1ps
`include "rsrc_defines.vh"
module rsrc_pin_filter
(
  input  wire clk_sys,
  input  wire rstn,
  input  wire pin_n,
  output wire low_seen
);
  // =============================================================
  // Low-run counter
  // =============================================================
  reg [2:0] cnt_q;
  reg [2:0] cnt_d;

  // Shorter pulses restart the count, so three-clock glitches never pass.
  always @*
  begin
    if (pin_n)
      cnt_d = 3'h0;
    else if (cnt_q != `RSRC_PIN_FILT_CYC)
      cnt_d = cnt_q + 3'h1;
    else
      cnt_d = cnt_q;
  end

  // Count register; reset clears it so no stale low run survives.
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_d;
  end

  assign low_seen = (cnt_q == `RSRC_PIN_FILT_CYC);
endmodule // rsrc_pin_filter

// ===== hw/rsrc_ctrl.v
// Purpose: Reset and stop recovery controller with AHB-Lite registers.
// Assumes: All inputs synchronous to clk_sys; analog detectors outside.
// Notes:   One note on implementation choices follows below.
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "rsrc_defines.vh"
module rsrc_ctrl
(
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        supply_ok,
  input  wire        supply_brownout,
  input  wire        stop_mode,
  input  wire        watchdog_timeout,
  input  wire        recovery_pin_change,
  input  wire        debug_pin_n,
  input  wire        reset_pin_in_n,
  output wire        reset_pin_out,
  output wire        reset_pin_oe,
  output wire        cpu_reset_n,
  output wire        periph_reset_n,
  output wire        gpio_force_input,
  output wire        brownout_enable,
  output wire        watchdog_irq,
  output wire        osc_start,
  output wire [15:0] vector_addr,
  output wire        vector_fetch
);
  // =============================================================
  // Sequencer states
  // =============================================================
  localparam [4:0] ST_RUN   = 5'b00001;
  localparam [4:0] ST_SUPP  = 5'b00010;
  localparam [4:0] ST_OSC   = 5'b00100;
  localparam [4:0] ST_HOLD  = 5'b01000;
  localparam [4:0] ST_VEC   = 5'b10000;

  reg  [4:0]  st_q;
  reg  [4:0]  st_d;
  reg  [12:0] cnt_q;
  reg  [12:0] cnt_d;
  reg         sys_q;
  reg         sys_d;
  reg  [7:0]  cause_q;
  reg  [7:0]  cause_d;
  reg  [7:0]  wdctl_q;
  reg  [7:0]  clkctl_q;
  reg  [7:0]  dbgctl_q;
  reg  [7:0]  cfg_q;
  reg         vec_q;
  reg         dph_q;
  reg         dwr_q;
  reg  [11:0] daddr_q;
  reg  [31:0] rdata_q;
  wire        pin_low;
  wire        pin_en;
  wire        wd_rst;
  wire        sys_evt;
  wire        rcv_evt;
  wire        addr_ph;
  wire        rd_cause;
  wire [12:0] hold_len;

  // Reset pin filter; a pulse must survive four samples.
  rsrc_pin_filter u_filt
  (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .pin_n    (reset_pin_in_n),
    .low_seen (pin_low)
  );

  // =============================================================
  // Event decode
  // =============================================================
  // Helper naming a register hit by word address, in the address or the data phase.
  function hit;
    input [11:0] a;
    input [11:0] r;
    begin
      hit = (a[11:2] == r[11:2]);
    end
  endfunction

  // Reset and recovery requests gathered from every source.
  assign pin_en  = cfg_q[`RSRC_CFG_PINEN];
  assign wd_rst  = watchdog_timeout & cfg_q[`RSRC_CFG_WDRES];
  assign watchdog_irq = watchdog_timeout & ~cfg_q[`RSRC_CFG_WDRES];
  // In stop, a low debug_pin_n requests a system reset at once; the pin filter is not applied to it.
  assign sys_evt = ~supply_ok | supply_brownout | wd_rst
                 | (pin_low & pin_en) | dbgctl_q[`RSRC_DEBUG_RST_BIT]
                 | (stop_mode & ~debug_pin_n);
  assign rcv_evt = stop_mode & (watchdog_timeout | recovery_pin_change);
  assign hold_len = cfg_q[`RSRC_CFG_XTAL] ? `RSRC_HOLD_LONG : `RSRC_HOLD_SHORT;
  assign brownout_enable = ~stop_mode | cfg_q[`RSRC_CFG_BOAO];

  // =============================================================
  // Sequencer
  // =============================================================
  // Supply problems restart from ST_SUPP from any state, so a brownout
  // during hold always reruns the full sequence.
  always @*
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    sys_d = sys_q;
    if (~supply_ok | supply_brownout)
    begin
      st_d  = ST_SUPP;
      cnt_d = 13'h0;
      sys_d = 1'b1;
    end
    else
    begin
      case (st_q)
        ST_RUN:
        begin
          if (sys_evt | rcv_evt)
          begin
            st_d  = ST_OSC;
            cnt_d = 13'h0;
            sys_d = sys_evt;
          end
        end
        ST_SUPP:
        begin
          st_d  = ST_OSC;
          cnt_d = 13'h0;
        end
        ST_OSC:
        begin
          if (cnt_q == `RSRC_OSC_START_CYC - 13'h1)
          begin
            st_d  = ST_HOLD;
            cnt_d = 13'h0;
          end
          else
            cnt_d = cnt_q + 13'h1;
        end
        ST_HOLD:
        begin
          if (cnt_q < hold_len - 13'h1)
            cnt_d = cnt_q + 13'h1;
          else if (!(pin_en & ~reset_pin_in_n))
            st_d = ST_VEC;
        end
        ST_VEC:
          st_d = ST_RUN;
        default:
          st_d = ST_SUPP;
      endcase
    end
  end

  // State, counter and vector pulse registers.
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q  <= ST_SUPP;
      cnt_q <= 13'h0;
      sys_q <= 1'b1;
      vec_q <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      sys_q <= sys_d;
      vec_q <= (st_q == ST_HOLD) & (st_d == ST_VEC);
    end
  end

  // Processor and peripherals idle outside ST_RUN; clocks are untouched.
  assign cpu_reset_n      = (st_q == ST_RUN);
  assign periph_reset_n   = (st_q == ST_RUN);
  assign gpio_force_input = (st_q != ST_RUN) & sys_q;
  assign osc_start        = (st_q == ST_OSC);
  assign vector_fetch     = vec_q;
  assign vector_addr      = vec_q ? `RSRC_VEC_LO : `RSRC_VEC_HI;
  // Open-drain indicator: only ever pulled low, during system resets, pin-triggered ones included.
  assign reset_pin_out    = 1'b0;
  assign reset_pin_oe     = sys_q & (st_q != ST_RUN) & (st_q != ST_VEC)
                          & (cnt_q < hold_len - 13'h1 | st_q != ST_HOLD);

  // =============================================================
  // Bus slave
  // =============================================================
  // The slave never stalls and never errors, so each transfer ends at once.
  assign addr_ph  = hsel & hready & htrans[1];
  assign rd_cause = dph_q & ~dwr_q & hit(daddr_q, `RSRC_ADDR_CAUSE);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // Address-phase capture for the data phase that follows.
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      dph_q   <= 1'b0;
      dwr_q   <= 1'b0;
      daddr_q <= 12'h000;
    end
    else
    begin
      dph_q   <= addr_ph;
      dwr_q   <= hwrite;
      daddr_q <= haddr;
    end
  end

  // Read data is registered from the address phase, valid in the data phase.
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 32'h00000000;
    else if (addr_ph & ~hwrite)
    begin
      if (hit(haddr, `RSRC_ADDR_CAUSE))
        rdata_q <= {24'h000000, cause_q};
      else if (hit(haddr, `RSRC_ADDR_WDCTL))
        rdata_q <= {24'h000000, wdctl_q};
      else if (hit(haddr, `RSRC_ADDR_CLKCTL))
        rdata_q <= {24'h000000, clkctl_q};
      else if (hit(haddr, `RSRC_ADDR_DBGCTL))
        rdata_q <= {24'h000000, dbgctl_q};
      else if (hit(haddr, `RSRC_ADDR_CFG))
        rdata_q <= {24'h000000, cfg_q};
      else if (hit(haddr, `RSRC_ADDR_STAT))
        rdata_q <= {27'h0, st_q};
      else
        rdata_q <= 32'h00000000;
    end
  end

  // =============================================================
  // Cause flags
  // =============================================================
  // The start of a sequence sets flags and wins over a same-cycle read.
  always @*
  begin
    cause_d = cause_q;
    if (rd_cause)
      cause_d = 8'h00;
    // A power-on style reset shows its flag again at vector time.
    if (vec_q & sys_q)
    begin
      if (dbgctl_q[`RSRC_DEBUG_RST_BIT] | cause_q[`RSRC_CAUSE_POR])
        cause_d = 8'h80;
    end
    if (st_q == ST_SUPP)
      cause_d = 8'h80;
    else if ((st_q == ST_RUN) & (st_d == ST_OSC))
    begin
      if (~rcv_evt | sys_evt)
      begin
        if (wd_rst)
          cause_d = 8'h20;
        else if (pin_low & pin_en)
          cause_d = 8'h10;
        else
          cause_d = 8'h80;
      end
      else
        cause_d = watchdog_timeout ? 8'h60 : 8'h40;
    end
  end

  // =============================================================
  // Control registers
  // =============================================================
  // System reset reloads all but cfg_q; recovery touches only two registers.
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cause_q  <= 8'h80;
      wdctl_q  <= `RSRC_WDCTL_RST;
      clkctl_q <= `RSRC_CLKCTL_RST;
      dbgctl_q <= 8'h00;
      cfg_q    <= `RSRC_CFG_RST;
    end
    else
    begin
      cause_q <= cause_d;
      if ((st_q == ST_OSC) & (cnt_q == 13'h0))
      begin
        wdctl_q  <= `RSRC_WDCTL_RST;
        clkctl_q <= `RSRC_CLKCTL_RST;
        if (sys_q)
          dbgctl_q <= 8'h00;
      end
      else if (dph_q & dwr_q)
      begin
        if (hit(daddr_q, `RSRC_ADDR_WDCTL))
          wdctl_q <= hwdata[7:0];
        else if (hit(daddr_q, `RSRC_ADDR_CLKCTL))
          clkctl_q <= hwdata[7:0];
        else if (hit(daddr_q, `RSRC_ADDR_DBGCTL))
          dbgctl_q <= hwdata[7:0];
        else if (hit(daddr_q, `RSRC_ADDR_CFG))
          cfg_q <= hwdata[7:0];
      end
    end
  end
endmodule // rsrc_ctrl

// ===== tb/rsrc_props.sv
// Purpose: Concurrent checks on the reset controller pins.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to the controller below the module.
`timescale 1ns/1ps
`include "rsrc_defines.vh"
// ==========================================================
// Checker
module rsrc_props
(
  input wire        clk_sys,
  input wire        rstn,
  input wire        supply_ok,
  input wire        reset_pin_in_n,
  input wire        reset_pin_oe,
  input wire        reset_pin_out,
  input wire        cpu_reset_n,
  input wire        periph_reset_n,
  input wire        osc_start,
  input wire        watchdog_irq,
  input wire [15:0] vector_addr,
  input wire        vector_fetch
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  reg [12:0] hold_q;
  // Reset cycles after the oscillator wait; loose by three edges on purpose.
  always @(posedge clk_sys or negedge rstn)
    if (!rstn)
      hold_q <= 13'h0000;
    else if (osc_start || cpu_reset_n)
      hold_q <= 13'h0000;
    else
      hold_q <= hold_q + 13'h0001;
  property p_hold; $rose(cpu_reset_n) |-> hold_q >= 13'h0040; endproperty
  a_hold: assert property (p_hold) else $error("early release");
  property p_osc; osc_start |-> !cpu_reset_n; endproperty
  a_osc: assert property (p_osc) else $error("run during osc wait");
  property p_idle; periph_reset_n == cpu_reset_n; endproperty
  a_idle: assert property (p_idle) else $error("peripherals out of step");
  property p_drv; reset_pin_oe |-> !cpu_reset_n && !reset_pin_out; endproperty
  a_drv: assert property (p_drv) else $error("pin driven outside reset");
  property p_vec;
    vector_fetch |-> (vector_addr == `RSRC_VEC_LO && !cpu_reset_n)
      ##1 (cpu_reset_n && vector_addr == `RSRC_VEC_HI);
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector address");
  property p_irq; watchdog_irq |-> cpu_reset_n ##1 !watchdog_irq; endproperty
  a_irq: assert property (p_irq) else $error("bad watchdog irq");
  property p_short;
    ($fell(reset_pin_in_n) && cpu_reset_n) ##1 !reset_pin_in_n ##1 reset_pin_in_n
      |-> cpu_reset_n [*6];
  endproperty
  a_short: assert property (p_short) else $error("short pulse acted");
  property p_long; !reset_pin_in_n [*7] |-> !cpu_reset_n; endproperty
  a_long: assert property (p_long) else $error("long pulse ignored");
  property p_rel; $rose(cpu_reset_n) |-> $past(reset_pin_in_n); endproperty
  a_rel: assert property (p_rel) else $error("released with pin low");
  property p_bo; !supply_ok ##1 !supply_ok |-> !cpu_reset_n; endproperty
  a_bo: assert property (p_bo) else $error("run with low supply");
endmodule // rsrc_props

bind rsrc_ctrl rsrc_props i_rsrc_props (.clk_sys, .rstn, .supply_ok, .reset_pin_in_n,
  .reset_pin_oe, .reset_pin_out, .cpu_reset_n, .periph_reset_n, .osc_start,
  .watchdog_irq, .vector_addr, .vector_fetch);

// ===== tb/rsrc_partner.sv
// Purpose: Outside party on the shared reset line.
// Assumes: Line has a pull-up; both ends pull low only.
// Notes:   Holds the line low for a commanded number of cycles.
`timescale 1ns/1ps
// ==========================================================
// Reset line partner
module rsrc_partner
(
  input  wire        clk_sys,
  input  wire        go,
  input  wire [11:0] low_len,
  input  wire        reset_pin_oe,
  input  wire        reset_pin_out,
  output wire        reset_pin_in_n
);
  reg [11:0] cnt_q = 12'h000;
  // Counting down keeps each pulse an exact width.
  always @(posedge clk_sys)
    if (go)
      cnt_q <= low_len;
    else if (cnt_q != 12'h000)
      cnt_q <= cnt_q - 12'h001;
  // The pull-up wins unless either party pulls low.
  assign reset_pin_in_n = !((reset_pin_oe && !reset_pin_out) || cnt_q != 12'h000);
endmodule // rsrc_partner

// ===== tb/test_reset_and_stop_recovery_ctrl.sv
// Purpose: Self-checking bench for the reset controller.
// Assumes: Bus answers at once, yet every wait is bounded.
// Notes:   Reads queue expected data; a monitor compares them.
`timescale 1ns/1ps
`include "rsrc_defines.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
// ==========================================================
// Bench
module test_reset_and_stop_recovery_ctrl;
  reg        clk_sys = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
  reg        supply_ok = 1'b0, supply_brownout = 1'b0, stop_mode = 1'b0, dp_q = 1'b0;
  reg        watchdog_timeout = 1'b0, recovery_pin_change = 1'b0, debug_pin_n = 1'b1;
  reg [11:0] haddr = 12'h000, low_len = 12'h000;
  reg [1:0]  htrans = 2'h0;
  reg [31:0] hwdata = 32'h00000000, ev;
  reg [7:0]  rnd = 8'h1F;
  wire [31:0] hrdata;
  wire [15:0] vector_addr;
  wire       hreadyout, reset_pin_out, reset_pin_oe, cpu_reset_n, reset_pin_in_n;
  int        fail_count = 0, n_compared = 0, irq_n = 0;
  reg [31:0] exp_q[$];
  always #2.5 clk_sys = ~clk_sys;
  wire       wd_irq, hresp, gpio_force_input, brownout_enable;
  rsrc_ctrl i_rsrc_ctrl (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .supply_ok, .supply_brownout,
    .stop_mode, .watchdog_timeout, .recovery_pin_change, .debug_pin_n, .reset_pin_in_n,
    .reset_pin_out, .reset_pin_oe, .cpu_reset_n, .periph_reset_n(), .gpio_force_input,
    .brownout_enable, .watchdog_irq(wd_irq), .osc_start(), .vector_addr,
    .vector_fetch());
  rsrc_partner i_rsrc_partner (.clk_sys, .go, .low_len, .reset_pin_oe, .reset_pin_out,
    .reset_pin_in_n);
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task summarize();
  begin
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task lim(input bit bad);
    if (bad)
    begin
      fail_count++;
      summarize();
    end
  endtask
  // Waits for hready under a bound; the bus gives no promise of latency.
  task rdy();
    int k;
  begin
    @(posedge clk_sys);
    for (k = 0; hreadyout !== 1'b1 && k < 50; k++)
      @(posedge clk_sys);
    lim(hreadyout !== 1'b1);
  end
  endtask
  task bus(input [11:0] a, input w, input [31:0] d, input [31:0] e);
  begin
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    rdy();
    if (!w)
      exp_q.push_back(e);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    dp_q <= !w;
    rdy();
    dp_q <= 1'b0;
  end
  endtask
  task after(input [7:0] c);
  begin
    bus(`RSRC_ADDR_CAUSE, 1'b0, 32'h00000000, {24'h000000, c});
    bus(`RSRC_ADDR_CLKCTL, 1'b0, 32'h00000000, {24'h000000, `RSRC_CLKCTL_RST});
  end
  endtask
  // At least 20 cycles, then on until the processor runs; sampled mid-cycle.
  task span(input int lo, input int hi);
    int k;
  begin
    for (k = 0; (k < 20 || cpu_reset_n !== 1'b1) && k < 7000; k++)
      @(negedge clk_sys);
    @(posedge clk_sys);
    $display("reset span %0d cycles", k);
    `CHK(k >= lo && k <= hi, 1'b1)
    lim(k >= 7000);
  end
  endtask
  task pin(input [11:0] n);
  begin
    go <= 1'b1;
    low_len <= n;
    @(posedge clk_sys);
    go <= 1'b0;
  end
  endtask
  // Read data is taken at the edge that ends the data phase.
  always @(posedge clk_sys)
  begin
    if (wd_irq === 1'b1)
      irq_n++;
    if (dp_q && hreadyout === 1'b1)
    begin
      ev = exp_q.pop_front();
      `CHK({hresp, hrdata}, {1'b0, ev})
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (30) @(posedge clk_sys);
    `CHK({cpu_reset_n, reset_pin_oe, gpio_force_input}, 3'b011)
    supply_ok <= 1'b1;
    span(866, 880);
    bus(`RSRC_ADDR_CAUSE, 1'b0, 32'h00000000, 32'h00000080);
    after(8'h00);
    bus(`RSRC_ADDR_CFG, 1'b0, 32'h00000000, 32'h0000000D);
    bus(`RSRC_ADDR_DBGCTL, 1'b0, 32'h00000000, 32'h00000000);
    bus(12'h100, 1'b0, 32'h00000000, 32'h00000000);
    rnd = lfsr(rnd);
    bus(`RSRC_ADDR_CLKCTL, 1'b1, {24'h000000, rnd}, 32'h00000000);
    bus(`RSRC_ADDR_CLKCTL, 1'b0, 32'h00000000, {24'h000000, rnd});
    $display("registers done");
    pin(12'h002);
    span(20, 20);
    pin(12'h004);
    span(866, 895);
    after(8'h10);
    pin(12'h3E8);
    span(1000, 1008);
    after(8'h10);
    $display("pin resets done");
    bus(`RSRC_ADDR_DBGCTL, 1'b1, 32'h00000001, 32'h00000000);
    span(866, 890);
    bus(`RSRC_ADDR_DBGCTL, 1'b0, 32'h00000000, 32'h00000000);
    after(8'h80);
    watchdog_timeout <= 1'b1;
    @(posedge clk_sys);
    watchdog_timeout <= 1'b0;
    span(866, 890);
    after(8'h20);
    bus(`RSRC_ADDR_CFG, 1'b1, 32'h0000000C, 32'h00000000);
    watchdog_timeout <= 1'b1;
    @(posedge clk_sys);
    watchdog_timeout <= 1'b0;
    span(20, 20);
    `CHK(irq_n, 1)
    supply_brownout <= 1'b1;
    supply_ok <= 1'b0;
    repeat (50) @(posedge clk_sys);
    `CHK(cpu_reset_n, 1'b0)
    supply_brownout <= 1'b0;
    supply_ok <= 1'b1;
    span(866, 890);
    after(8'h80);
    $display("system resets done");
    bus(`RSRC_ADDR_CFG, 1'b1, 32'h0000000F, 32'h00000000);
    bus(`RSRC_ADDR_CLKCTL, 1'b1, 32'h00000055, 32'h00000000);
    stop_mode <= 1'b1;
    recovery_pin_change <= 1'b1;
    @(posedge clk_sys);
    recovery_pin_change <= 1'b0;
    span(5800, 5830);
    `CHK(brownout_enable, 1'b1)
    stop_mode <= 1'b0;
    after(8'h40);
    bus(`RSRC_ADDR_CFG, 1'b0, 32'h00000000, 32'h0000000F);
    // Always-on option off, so stop mode must gate the brownout detector.
    bus(`RSRC_ADDR_CFG, 1'b1, 32'h00000009, 32'h00000000);
    stop_mode <= 1'b1;
    debug_pin_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    `CHK(brownout_enable, 1'b0)
    debug_pin_n <= 1'b1;
    stop_mode <= 1'b0;
    span(860, 890);
    after(8'h80);
    $display("stop tests done");
    summarize();
  end
endmodule // test_reset_and_stop_recovery_ctrl
